// ### eif_top.sv
// External interrupt input filter: six pins through noise cancellers and
// trigger detectors into request latches, with a small register file.
// Assumes pins and low_freq_clock are asynchronous; op_mode and the
// register port are driven on mclk. mclk is the gear clock.
`timescale 1ns/1ps
`include "eif_defs.svh"

module eif_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic irq_pin_zero,
    input wire logic irq_pin_one,
    input wire logic irq_pin_two,
    input wire logic irq_pin_three,
    input wire logic irq_pin_four,
    input wire logic irq_pin_five,
    input wire logic [5:0] pin_output_mode,
    input wire logic low_freq_clock,
    input wire eif_pkg::eif_mode_t op_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic [5:0] irq_pending,
    output logic [5:0] irq_service
);
    import eif_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic is_fast(input eif_mode_t m);
        return (m == EIF_FAST_RUN) || (m == EIF_FAST_HALT);
    endfunction

    function automatic logic is_slow(input eif_mode_t m);
        return (m == EIF_SLOW_RUN) || (m == EIF_SLOW_HALT);
    endfunction

    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    function automatic logic [3:0] ctrl_off(input int k);
        return 4'(`EIF_OFF_CTRL1 + k - 1);
    endfunction

    function automatic logic interval_tick(input eif_code_t nc, input logic [3:0] pre);
        case (nc)
            `EIF_NC_DIV1: return 1'b1;
            `EIF_NC_DIV4: return pre[1:0] == 2'h0;
            `EIF_NC_DIV8: return pre[2:0] == 3'h0;
            default: return pre == 4'h0;
        endcase
    endfunction

    function automatic logic trig_hit(input eif_code_t es, input logic prev, input logic cur,
                                      input logic allow_level);
        case (es)
            `EIF_TRIG_RISE: return !prev && cur;
            `EIF_TRIG_FALL: return prev && !cur;
            `EIF_TRIG_BOTH: return prev ^ cur;
            default: return allow_level && cur;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic lf_meta;
    logic lf_sync;
    logic lf_prev;
    logic [5:0] next_pin_meta;
    logic [5:0] next_pin_sync;
    logic next_lf_meta;
    logic next_lf_sync;
    logic next_lf_prev;

    assign pin_raw = {irq_pin_five, irq_pin_four, irq_pin_three, irq_pin_two, irq_pin_one, irq_pin_zero};

    always_comb
    begin
        next_pin_meta = pin_raw;
        next_pin_sync = pin_meta;
        next_lf_meta = low_freq_clock;
        next_lf_sync = lf_meta;
        next_lf_prev = lf_sync;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
            lf_meta <= 1'b0;
            lf_sync <= 1'b0;
            lf_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
            lf_meta <= next_lf_meta;
            lf_sync <= next_lf_sync;
            lf_prev <= next_lf_prev;
        end
    end

    // ----------------------------------------------------------------
    // Sampling rates
    // ----------------------------------------------------------------
    // The low clock is far slower than mclk, so its rising edge becomes a
    // one-cycle enable; a low clock near mclk rate would be undersampled.
    logic fast_mode;
    logic slow_mode;
    logic mode_active;
    logic fs_tick;
    logic fs4_tick;
    logic [1:0] fs_div;
    logic [3:0] prescale;
    logic [1:0] next_fs_div;
    logic [3:0] next_prescale;

    assign fast_mode = is_fast(op_mode);
    assign slow_mode = is_slow(op_mode);
    assign mode_active = fast_mode || slow_mode;
    assign fs_tick = lf_sync && !lf_prev;
    assign fs4_tick = slow_mode && fs_tick && (fs_div == `EIF_SLOW_DIV_LAST);

    always_comb
    begin
        next_fs_div = fs_div;
        next_prescale = prescale;
        if (slow_mode && fs_tick)
            next_fs_div = fs_div + 2'h1;
        if (fast_mode)
            next_prescale = prescale + 4'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            fs_div <= 2'h0;
            prescale <= 4'h0;
        end
        else
        begin
            fs_div <= next_fs_div;
            prescale <= next_prescale;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [5:0] ext_irq_clock_gate;
    logic [5:0] irq_enable;
    logic master_irq_flag;
    logic [5:0] irq_latch;
    logic [3:0] ext_irq_control [1:4];
    logic [4:1] captured_level;
    logic [5:0] next_gate;
    logic [5:0] next_enable;
    logic next_master;
    logic [5:0] next_latch;
    logic [3:0] next_control [1:4];
    logic [4:1] next_captured;
    logic [7:0] next_rdata;
    logic [5:0] latch_clear;

    // Per-source filter outputs and request strobes
    logic [5:0] filt_level;
    logic [5:0] prev_level;
    logic [5:0] next_prev_level;
    logic [5:0] src_run;
    logic [5:0] hit;

    // ----------------------------------------------------------------
    // Per-source filter and trigger
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `EIF_NSRC; i++)
        begin : g_src
            logic tick;
            logic three;
            logic din;

            // Output-mode pins read low, which can itself fire a request
            assign din = pin_output_mode[i] ? 1'b0 : pin_sync[i];
            assign src_run[i] = mode_active && ext_irq_clock_gate[i];

            if (i == 0 || i == `EIF_NSRC - 1)
            begin : g_fixed
                // Two agreeing samples per gear cycle or per slow tick
                assign tick = fast_mode ? 1'b1 : fs4_tick;
                assign three = 1'b0;
                assign hit[i] = src_run[i] && trig_hit(`EIF_TRIG_FALL, prev_level[i], filt_level[i], 1'b0);
            end
            else
            begin : g_conf
                eif_code_t es;
                assign es = ext_irq_control[i][`EIF_FLD_ES_LSB +: 2];
                assign tick = fast_mode ? interval_tick(ext_irq_control[i][`EIF_FLD_NC_LSB +: 2], prescale)
                                        : fs4_tick;
                assign three = fast_mode;
                // Level mode exists only on pin four; elsewhere code 11 is dead
                assign hit[i] = src_run[i] && trig_hit(es, prev_level[i], filt_level[i], i == 4);
            end

            eif_filter u_filter (
                .mclk(mclk),
                .reset(reset),
                .run(src_run[i]),
                .tick(tick),
                .three(three),
                .din(din),
                .level(filt_level[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register update
    // ----------------------------------------------------------------
    always_comb
    begin
        next_gate = ext_irq_clock_gate;
        next_enable = irq_enable;
        next_master = master_irq_flag;
        next_control = ext_irq_control;
        next_captured = captured_level;
        next_prev_level = filt_level;
        next_rdata = 8'h00;
        latch_clear = 6'h00;
        if (reg_write)
        begin
            if (addr_hit(reg_addr, `EIF_OFF_GATE))
                next_gate = reg_wdata[5:0];
            if (addr_hit(reg_addr, `EIF_OFF_ENABLE))
                next_enable = reg_wdata[5:0];
            if (addr_hit(reg_addr, `EIF_OFF_MASTER))
                next_master = reg_wdata[0];
            if (addr_hit(reg_addr, `EIF_OFF_LATCH))
                latch_clear = reg_wdata[5:0];
            for (int k = 1; k <= 4; k++)
            begin
                if (addr_hit(reg_addr, ctrl_off(k)))
                    next_control[k] = reg_wdata[3:0];
            end
        end
        // A request in the clearing cycle survives the clear
        next_latch = (irq_latch & ~latch_clear) | hit;
        for (int k = 1; k <= 4; k++)
        begin
            if (hit[k])
                next_captured[k] = filt_level[k];
        end
        if (reg_read)
        begin
            if (addr_hit(reg_addr, `EIF_OFF_GATE))
                next_rdata = {2'b00, ext_irq_clock_gate};
            if (addr_hit(reg_addr, `EIF_OFF_ENABLE))
                next_rdata = {2'b00, irq_enable};
            if (addr_hit(reg_addr, `EIF_OFF_MASTER))
                next_rdata = {7'h00, master_irq_flag};
            if (addr_hit(reg_addr, `EIF_OFF_LATCH))
                next_rdata = {2'b00, irq_latch};
            for (int k = 1; k <= 4; k++)
            begin
                if (addr_hit(reg_addr, ctrl_off(k)))
                    next_rdata = {3'b000, captured_level[k], ext_irq_control[k]};
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ext_irq_clock_gate <= `EIF_RST_GATE;
            irq_enable <= `EIF_RST_ENABLE;
            master_irq_flag <= 1'b0;
            irq_latch <= 6'h00;
            for (int k = 1; k <= 4; k++)
                ext_irq_control[k] <= `EIF_RST_CTRL;
            captured_level <= 4'h0;
            prev_level <= 6'h00;
            reg_rdata <= 8'h00;
        end
        else
        begin
            ext_irq_clock_gate <= next_gate;
            irq_enable <= next_enable;
            master_irq_flag <= next_master;
            irq_latch <= next_latch;
            ext_irq_control <= next_control;
            captured_level <= next_captured;
            prev_level <= next_prev_level;
            reg_rdata <= next_rdata;
        end
    end

    assign irq_pending = irq_latch;
    assign irq_service = master_irq_flag ? (irq_latch & irq_enable) : 6'h00;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_pin1_reserved;
        ext_irq_control[1][`EIF_FLD_ES_LSB +: 2] == `EIF_TRIG_LEVEL;
    endsequence

    sequence s_pin4_level_high;
        ext_irq_control[4][`EIF_FLD_ES_LSB +: 2] == `EIF_TRIG_LEVEL && src_run[4] && filt_level[4];
    endsequence

    sequence s_slow_quiet;
        !fs4_tick [*7];
    endsequence

    a_pin_zero_fall: assert property (hit[0] |-> prev_level[0] && !filt_level[0])
        else $error("pin zero request without a falling edge");

    a_pin_five_fall: assert property (hit[5] |-> prev_level[5] && !filt_level[5])
        else $error("pin five request without a falling edge");

    a_service_needs_both: assert property (irq_service != 6'h00 |-> master_irq_flag
        && (irq_service & ~irq_enable) == 6'h00)
        else $error("service without master flag or enable");

    a_reserved_silent: assert property (s_pin1_reserved |-> !hit[1])
        else $error("reserved trigger code produced a request");

    a_pin4_level_req: assert property (s_pin4_level_high |-> hit[4] ##1 irq_latch[4])
        else $error("pin four level mode missed a request");

    a_level_capture: assert property (hit[2] |=> captured_level[2] == $past(filt_level[2]))
        else $error("captured level not updated on request");

    a_halt_no_request: assert property (!mode_active |-> hit == 6'h00)
        else $error("request while sampling is halted");

    a_gate_blocks_src: assert property ((hit & ~ext_irq_clock_gate) == 6'h00)
        else $error("request from a gated source");

    a_reset_gate_off: assert property ($past(reset) |-> ext_irq_clock_gate == 6'h00 && captured_level == 4'h0)
        else $error("gate or level bits not cleared by reset");

    a_slow_tick_spacing: assert property (fs4_tick |=> s_slow_quiet)
        else $error("slow sampling ticks too close together");

    a_latch_set_wins: assert property (hit[3] |=> irq_latch[3])
        else $error("request lost in the latch");

endmodule // eif_top

// ### eif_defs.svh
// Constants for the external interrupt input filter: register offsets,
// field positions, reset values and timing counts.
// Assumes it is included by its bare name from each file that uses its macros.
//
// Notes on behaviour
// - Pin zero requests only on a falling edge; trigger and filter are fixed.
// - Pin five requests only on a falling edge; trigger and filter are fixed.
// - Fixed pins, fast modes: reject under one gear period, accept two or more.
// - Fixed pins, slow modes: reject under four low periods, accept eight or more.
// - A request is serviced only with master flag and source enable both set.
// - Pins one to three trigger: 00 rising, 01 falling, 10 both, 11 reserved.
// - Pin four trigger code 11 gives a high-level request.
// - Each request on pins one to four captures the filtered level into a readable level bit.
// - Level bit reads 0 after reset or low level, 1 for high level.
// - Fast modes: configurable filter resamples and needs three equal samples.
// - Interval field: 00 gear clock, 01/10/11 gear clock divided by 4/8/16.
// - Fast modes: reject under two intervals, accept over three plus one period.
// - Slow modes: sample at low clock over four, accept two equal samples.
// - Deep halt and stop modes halt sampling; run or halt modes resume it.
// - Clock-gate bit 0 stops the source logic; 1 makes it usable.
// - All clock-gate bits are 0 after reset.
// - A pin in output mode reads low, giving a request; software disables first.
`ifndef EIF_DEFS_SVH
`define EIF_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EIF_ADDR_W 4
`define EIF_DATA_W 8
`define EIF_NSRC 6
`define EIF_OFF_GATE 4'h0
`define EIF_OFF_ENABLE 4'h1
`define EIF_OFF_MASTER 4'h2
`define EIF_OFF_LATCH 4'h3
`define EIF_OFF_CTRL1 4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define EIF_FLD_NC_LSB 0
`define EIF_FLD_ES_LSB 2
`define EIF_FLD_LVL 4
`define EIF_TRIG_RISE 2'h0
`define EIF_TRIG_FALL 2'h1
`define EIF_TRIG_BOTH 2'h2
`define EIF_TRIG_LEVEL 2'h3
`define EIF_NC_DIV1 2'h0
`define EIF_NC_DIV4 2'h1
`define EIF_NC_DIV8 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EIF_RST_GATE 6'h00
`define EIF_RST_ENABLE 6'h00
`define EIF_RST_CTRL 4'h0
`define EIF_RST_LEVEL 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EIF_MCLK_PERIOD_NS 10
`define EIF_SLOW_DIV 4
`define EIF_SLOW_DIV_LAST 2'(`EIF_SLOW_DIV - 1)

`endif

// ### eif_pkg.sv
// Types shared by the external interrupt input filter.
// Assumes the system mode controller drives the mode code on mclk.
package eif_pkg;

    typedef enum logic [2:0] {
        EIF_FAST_RUN = 3'h0,
        EIF_FAST_HALT = 3'h1,
        EIF_SLOW_RUN = 3'h2,
        EIF_SLOW_HALT = 3'h3,
        EIF_DEEP_HALT_FAST = 3'h4,
        EIF_DEEP_HALT_SLOW = 3'h5,
        EIF_STOPPED = 3'h6
    } eif_mode_t;

    typedef logic [1:0] eif_code_t;

endpackage

// ### eif_filter.sv
// Noise canceller for one interrupt source.
// Assumes din is already synchronised to mclk and tick is a one-cycle enable.
`timescale 1ns/1ps
`include "eif_defs.svh"

module eif_filter (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic tick,
    input wire logic three,
    input wire logic din,
    output logic level
);
    import eif_pkg::*;

    logic [1:0] hist;
    logic [1:0] next_hist;
    logic next_level;

    // ----------------------------------------------------------------
    // Sampling
    // ----------------------------------------------------------------
    always_comb
    begin
        next_hist = hist;
        next_level = level;
        // Frozen while the source clock is gated or the mode halts sampling
        if (run && tick)
        begin
            next_hist = {hist[0], din};
            if (three)
            begin
                if (hist[1] == din && hist[0] == din)
                    next_level = din;
            end
            else if (hist[0] == din)
            begin
                next_level = din;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            hist <= 2'h0;
            level <= `EIF_RST_LEVEL;
        end
        else
        begin
            hist <= next_hist;
            level <= next_level;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_level_needs_agree: assert property ($changed(level) |-> $past(run && tick) && $past(din) == level
        && ($past(hist[0]) == level) && (!$past(three) || $past(hist[1]) == level))
        else $error("filter level changed without agreeing samples");

    a_filter_frozen_idle: assert property (!$past(run) |-> $stable(level) && $stable(hist))
        else $error("filter moved while halted or gated");

endmodule // eif_filter

// ### eif_pin_src.sv
// Far-side model: six external interrupt sources and the slow clock.
// Assumes the bench calls set_pin and pulse one at a time, on mclk.
`timescale 1ns/1ps

module eif_pin_src (
    input wire logic mclk,
    output logic [5:0] pins,
    output logic slow_clk
);
    logic [3:0] div_cnt = 4'h0;

    initial pins = 6'h00;

    // Slow clock at one sixteenth of mclk, so each phase spans eight mclk cycles
    always @(posedge mclk)
    begin
        div_cnt <= div_cnt + 4'h1;
    end
    assign slow_clk = div_cnt[3];

    task set_pin(input int p, input logic v);
        @(posedge mclk);
        pins[p] <= v;
    endtask

    // Single isolated pulses only; bursts of noise would defeat the filter
    task pulse(input int p, input int w);
        @(posedge mclk);
        pins[p] <= ~pins[p];
        repeat (w) @(posedge mclk);
        pins[p] <= ~pins[p];
    endtask
endmodule // eif_pin_src

// ### test_external_irq_input_filter.sv
// Self-checking bench for the external interrupt input filter.
// Assumes eif_pin_src stands at the pins and drives the slow clock.
`timescale 1ns/1ps
`include "eif_defs.svh"

module test_external_irq_input_filter;
    import eif_pkg::*;

    typedef struct packed {
        logic [2:0] pin;
        logic [3:0] ctl;
        logic idle;
        logic [7:0] width;
        logic pend;
        logic lvl;
    } eif_row_t;

    // Width 0 means a step to the opposite level, otherwise a pulse of that many cycles
    localparam eif_row_t ROWS [19] = '{
        '{3'd0, 4'h0, 1'b1, 8'd0, 1'b1, 1'b0}, '{3'd0, 4'h0, 1'b0, 8'd0, 1'b0, 1'b0},
        '{3'd5, 4'h0, 1'b1, 8'd0, 1'b1, 1'b0}, '{3'd5, 4'h0, 1'b0, 8'd0, 1'b0, 1'b0},
        '{3'd1, 4'h0, 1'b0, 8'd0, 1'b1, 1'b1}, '{3'd2, 4'h4, 1'b1, 8'd0, 1'b1, 1'b0},
        '{3'd3, 4'h8, 1'b0, 8'd0, 1'b1, 1'b1}, '{3'd3, 4'h8, 1'b1, 8'd0, 1'b1, 1'b0},
        '{3'd1, 4'hC, 1'b0, 8'd0, 1'b0, 1'b0}, '{3'd4, 4'hC, 1'b0, 8'd0, 1'b1, 1'b1},
        '{3'd2, 4'h1, 1'b0, 8'd0, 1'b1, 1'b1}, '{3'd2, 4'h2, 1'b0, 8'd0, 1'b1, 1'b1},
        '{3'd2, 4'h3, 1'b0, 8'd0, 1'b1, 1'b1}, '{3'd0, 4'h0, 1'b1, 8'd2, 1'b1, 1'b0},
        '{3'd5, 4'h0, 1'b1, 8'd2, 1'b1, 1'b0}, '{3'd1, 4'h4, 1'b1, 8'd1, 1'b0, 1'b0},
        '{3'd1, 4'h4, 1'b1, 8'd5, 1'b1, 1'b0}, '{3'd1, 4'h7, 1'b1, 8'd20, 1'b0, 1'b0},
        '{3'd1, 4'h7, 1'b1, 8'd60, 1'b1, 1'b0}
    };
    localparam eif_mode_t HALTS [3] = '{EIF_DEEP_HALT_FAST, EIF_DEEP_HALT_SLOW, EIF_STOPPED};

    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] pins;
    logic lfclk;
    logic [5:0] out_mode = 6'h00;
    eif_mode_t op_mode = EIF_FAST_RUN;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] d;
    logic [5:0] irq_pending;
    logic [5:0] irq_service;
    int miscompares = 0;
    int check_count = 0;

    eif_pin_src src (.mclk(mclk), .pins(pins), .slow_clk(lfclk));

    eif_top DUT (
        .mclk(mclk), .reset(reset),
        .irq_pin_zero(pins[0]), .irq_pin_one(pins[1]), .irq_pin_two(pins[2]),
        .irq_pin_three(pins[3]), .irq_pin_four(pins[4]), .irq_pin_five(pins[5]),
        .pin_output_mode(out_mode), .low_freq_clock(lfclk), .op_mode(op_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .irq_pending(irq_pending), .irq_service(irq_service)
    );

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task run_row(input eif_row_t r);
        logic [3:0] a;
        a = 4'(`EIF_OFF_CTRL1 + r.pin - 3'd1);
        if (r.pin inside {[1:4]})
            wr(a, {4'h0, r.ctl});
        src.set_pin(int'(r.pin), r.idle);
        repeat (120) @(posedge mclk);
        wr(`EIF_OFF_LATCH, 8'h3F);
        if (r.width == 8'd0)
            src.set_pin(int'(r.pin), ~r.idle);
        else
            src.pulse(int'(r.pin), int'(r.width));
        repeat (120) @(posedge mclk);
        rd(`EIF_OFF_LATCH, d);
        chk({7'h00, d[r.pin]}, {7'h00, r.pend});
        if (r.pin inside {[1:4]} && r.pend)
        begin
            rd(a, d);
            chk({7'h00, d[`EIF_FLD_LVL]}, {7'h00, r.lvl});
        end
    endtask

    initial
    begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        wr(`EIF_OFF_GATE, 8'h3F);
        wr(`EIF_OFF_ENABLE, 8'h3F);
        wr(`EIF_OFF_MASTER, 8'h01);
        foreach (ROWS[i]) run_row(ROWS[i]);
        wr(`EIF_OFF_LATCH, 8'h3F);
        src.pulse(0, 3);
        repeat (20) @(posedge mclk);
        wr(`EIF_OFF_MASTER, 8'h00);
        #1 chk({7'h00, irq_service[0]}, 8'h00);
        wr(`EIF_OFF_MASTER, 8'h01);
        #1 chk({7'h00, irq_service[0]}, 8'h01);
        wr(`EIF_OFF_ENABLE, 8'h3E);
        #1 chk({7'h00, irq_service[0]}, 8'h00);
        wr(`EIF_OFF_LATCH, 8'h01);
        #1 chk({7'h00, irq_pending[0]}, 8'h00);
        wr(`EIF_OFF_GATE, 8'h3E);
        src.pulse(0, 10);
        repeat (40) @(posedge mclk);
        chk({7'h00, irq_pending[0]}, 8'h00);
        wr(`EIF_OFF_GATE, 8'h3F);
        foreach (HALTS[i])
        begin
            @(posedge mclk);
            op_mode <= HALTS[i];
            src.pulse(0, 10);
            repeat (40) @(posedge mclk);
            chk({7'h00, irq_pending[0]}, 8'h00);
        end
        // Resume in the fast halt mode so that code is exercised as well
        @(posedge mclk);
        op_mode <= EIF_FAST_HALT;
        repeat (20) @(posedge mclk);
        src.pulse(0, 10);
        repeat (40) @(posedge mclk);
        chk({7'h00, irq_pending[0]}, 8'h01);
        wr(`EIF_OFF_LATCH, 8'h01);
        @(posedge mclk);
        out_mode <= 6'h01;
        repeat (20) @(posedge mclk);
        chk({7'h00, irq_pending[0]}, 8'h01);
        out_mode <= 6'h00;
        wr(`EIF_OFF_ENABLE, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            op_mode <= (p == 0) ? EIF_SLOW_RUN : EIF_SLOW_HALT;
            repeat (192) @(posedge mclk);
            wr(`EIF_OFF_LATCH, 8'h3F);
            src.pulse(p, 32);
            repeat (300) @(posedge mclk);
            chk({7'h00, irq_pending[p]}, 8'h00);
            src.pulse(p, 128);
            repeat (300) @(posedge mclk);
            chk({7'h00, irq_pending[p]}, 8'h01);
        end
        op_mode <= EIF_FAST_RUN;
        reset <= 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        for (int a = 0; a < 10; a++)
        begin
            rd(4'(a), d);
            chk(d, 8'h00);
        end
        chk({2'b00, irq_pending}, 8'h00);
        stop_test;
    end

    // Whole run needs roughly 7100 cycles
    initial
    begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        stop_test;
    end
endmodule // test_external_irq_input_filter
